// File: rtl/ctc_pkg.sv
// Package: register map, fields and modes of the capture timer control block
package ctc_pkg;
  localparam logic [3:0] ADDR_CTRL_PRIMARY = 4'h0;
  localparam logic [3:0] ADDR_CTRL_SECONDARY = 4'h1;
  localparam logic [3:0] ADDR_EVENT_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_INT_CONTROL = 4'h5;
  localparam logic [3:0] ADDR_INT_FLAGS = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_COMPARE = 4'h8;
  localparam logic [3:0] ADDR_CAPTURE = 4'h9;
  localparam logic [3:0] ADDR_COUNT = 4'ha;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_SYNC = 4;
  localparam int BIT_STANDBY = 6;
  localparam int CLOCK_SOURCE_SELECT_LO = 1;
  localparam int BIT_ASYNC = 6;
  localparam int BIT_INIT = 5;
  localparam int BIT_OUTEN = 4;
  localparam int BIT_FILTER = 6;
  localparam int BIT_EDGE = 4;
  localparam int BIT_CAPTEN = 0;
  localparam int FILTER_DEPTH = 4;
  localparam logic [1:0] CLK_UNDIV = 2'h0;
  localparam logic [1:0] CLK_HALF = 2'h1;
  localparam logic [1:0] CLK_COMPANION = 2'h2;
  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'h0,
    MODE_TIMEOUT = 3'h1,
    MODE_CAPTURE = 3'h2,
    MODE_FREQ = 3'h3,
    MODE_WIDTH = 3'h4,
    MODE_FREQ_WIDTH = 3'h5,
    MODE_SINGLE = 3'h6,
    MODE_EIGHT_BIT_PULSE_MOD_MODE = 3'h7
  } ctc_mode_type;
endpackage

// File: rtl/ctc_noise_filter.sv
// Four-sample noise canceller with bypass
module ctc_noise_filter #(
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic event_i,
  output logic level_o
);
  logic [DEPTH-1:0] hist;
  logic held;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist <= '0;
    end else begin
      hist <= {hist[DEPTH-2:0], event_i};
    end
  end

  // Level passes only after DEPTH equal samples
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held <= 1'b0;
    end else if (&hist) begin
      held <= 1'b1;
    end else if (~|hist) begin
      held <= 1'b0;
    end
  end

  assign level_o = enable_i ? held : event_i;
endmodule

// File: rtl/ctc_edge_detect.sv
// Rising and falling edge detector for the event level
module ctc_edge_detect (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic level_i,
  output logic rise_o,
  output logic fall_o
);
  logic last;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last <= 1'b0;
    end else begin
      last <= level_i;
    end
  end

  assign rise_o = level_i & ~last;
  assign fall_o = ~level_i & last;
endmodule

// File: rtl/ctc_timer.sv
// Capture timer control: registers, clock select, event actions and output
module ctc_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] adr_i,
  input wire logic [7:0] dat_i,
  output logic [7:0] dat_o,
  input wire logic we_i,
  input wire logic sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic event_i,
  input wire logic companion_tick_i,
  input wire logic companion_restart_i,
  input wire logic standby_i,
  output logic compare_out_o,
  output logic irq_o,
  output logic running_o
);
  logic [7:0] control_primary;
  logic [7:0] control_secondary;
  logic [7:0] event_control;
  logic irq_enable;
  logic event_capture_flag;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] compare;
  logic [WIDTH-1:0] capture;
  logic run;
  logic half_phase;
  logic tick;
  logic fpw_armed;
  logic fpw_captured;
  logic level;
  logic rise;
  logic fall;
  logic sel_edge;
  logic other_edge;
  logic access;
  logic wr;
  logic rd;
  logic ev_ok;
  logic do_start;
  logic do_stop;
  logic do_clear;
  logic do_capture;
  logic do_flag;
  logic at_top;
  logic out_level;
  logic out_set;
  logic cap_mode;
  logic [7:0] next_dat;
  ctc_pkg::ctc_mode_type mode;
  logic [1:0] clk_sel;

  assign mode = ctc_pkg::ctc_mode_type'(control_secondary[2:0]);
  assign clk_sel = control_primary[ctc_pkg::CLOCK_SOURCE_SELECT_LO +: 2];
  assign access = cyc_i & stb_i & ~ack_o;
  assign wr = access & we_i & sel_i;
  assign rd = access & ~we_i;

  // Wishbone slave: ack one cycle after the strobe, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  always_comb begin
    next_dat = ctc_pkg::RESET_BYTE;
    unique case (adr_i)
      ctc_pkg::ADDR_CTRL_PRIMARY: next_dat = control_primary;
      ctc_pkg::ADDR_CTRL_SECONDARY: next_dat = control_secondary;
      ctc_pkg::ADDR_EVENT_CONTROL: next_dat = event_control;
      ctc_pkg::ADDR_INT_CONTROL: next_dat = {7'h00, irq_enable};
      ctc_pkg::ADDR_INT_FLAGS: next_dat = {7'h00, event_capture_flag};
      ctc_pkg::ADDR_STATUS: next_dat = {7'h00, run};
      ctc_pkg::ADDR_COMPARE: next_dat = compare[7:0];
      ctc_pkg::ADDR_CAPTURE: next_dat = capture[7:0];
      ctc_pkg::ADDR_COUNT: next_dat = count[7:0];
      default: next_dat = ctc_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= ctc_pkg::RESET_BYTE;
    end else if (rd) begin
      dat_o <= next_dat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_primary <= ctc_pkg::RESET_BYTE;
      control_secondary <= ctc_pkg::RESET_BYTE;
      event_control <= ctc_pkg::RESET_BYTE;
      irq_enable <= 1'b0;
      compare <= ctc_pkg::RESET_WORD;
    end else if (wr) begin
      unique case (adr_i)
        ctc_pkg::ADDR_CTRL_PRIMARY: control_primary <= dat_i & 8'h57;
        ctc_pkg::ADDR_CTRL_SECONDARY: control_secondary <= dat_i & 8'h77;
        ctc_pkg::ADDR_EVENT_CONTROL: event_control <= dat_i & 8'h51;
        ctc_pkg::ADDR_INT_CONTROL: irq_enable <= dat_i[0];
        ctc_pkg::ADDR_COMPARE: compare <= {8'h00, dat_i};
        default: irq_enable <= irq_enable;
      endcase
    end
  end

  // Clock enable tick; the reserved code never ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_phase <= 1'b0;
    end else begin
      half_phase <= ~half_phase;
    end
  end

  always_comb begin
    tick = 1'b0;
    unique case (clk_sel)
      ctc_pkg::CLK_UNDIV: tick = 1'b1;
      ctc_pkg::CLK_HALF: tick = half_phase;
      ctc_pkg::CLK_COMPANION: tick = companion_tick_i;
      default: tick = 1'b0;
    endcase
    // Standby halts unless run-in-standby; companion clock ignores the bit
    if (standby_i && !(control_primary[ctc_pkg::BIT_STANDBY] && clk_sel != ctc_pkg::CLK_COMPANION)) begin
      tick = 1'b0;
    end
    if (!control_primary[ctc_pkg::BIT_ENABLE]) begin
      tick = 1'b0;
    end
  end

  ctc_noise_filter #(.DEPTH(ctc_pkg::FILTER_DEPTH)) u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(event_control[ctc_pkg::BIT_FILTER]),
    .event_i(event_i),
    .level_o(level)
  );

  ctc_edge_detect u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(level),
    .rise_o(rise),
    .fall_o(fall)
  );

  assign ev_ok = event_control[ctc_pkg::BIT_CAPTEN] & control_primary[ctc_pkg::BIT_ENABLE];
  assign sel_edge = ev_ok & (event_control[ctc_pkg::BIT_EDGE] ? fall : rise);
  assign other_edge = ev_ok & (event_control[ctc_pkg::BIT_EDGE] ? rise : fall);
  assign at_top = run & tick & (count == compare);
  assign cap_mode = mode inside {ctc_pkg::MODE_CAPTURE, ctc_pkg::MODE_FREQ,
                                 ctc_pkg::MODE_WIDTH, ctc_pkg::MODE_FREQ_WIDTH};

  // Event actions per mode
  always_comb begin
    do_start = 1'b0;
    do_stop = 1'b0;
    do_clear = 1'b0;
    do_capture = 1'b0;
    do_flag = 1'b0;
    unique case (mode)
      ctc_pkg::MODE_PERIODIC, ctc_pkg::MODE_EIGHT_BIT_PULSE_MOD_MODE: begin
        do_flag = at_top;
      end
      ctc_pkg::MODE_TIMEOUT: begin
        do_start = sel_edge;
        do_stop = other_edge;
        do_flag = at_top;
      end
      ctc_pkg::MODE_CAPTURE: begin
        do_capture = sel_edge;
        do_flag = sel_edge;
      end
      ctc_pkg::MODE_FREQ: begin
        do_capture = sel_edge;
        do_clear = sel_edge;
        do_start = sel_edge;
        do_flag = sel_edge;
      end
      ctc_pkg::MODE_WIDTH: begin
        do_clear = sel_edge;
        do_start = sel_edge;
        do_capture = other_edge;
        do_flag = other_edge;
      end
      ctc_pkg::MODE_FREQ_WIDTH: begin
        if (sel_edge && !fpw_armed) begin
          do_clear = 1'b1;
          do_start = 1'b1;
        end else if (other_edge && fpw_armed && !fpw_captured) begin
          do_capture = 1'b1;
        end else if (sel_edge && fpw_captured) begin
          do_stop = 1'b1;
          do_flag = 1'b1;
        end
      end
      ctc_pkg::MODE_SINGLE: begin
        do_start = sel_edge & ~run;
        do_stop = at_top;
        do_flag = at_top;
      end
    endcase
  end

  // Combined-mode sequence tracking
  always_ff @(posedge clk_i) begin
    if (rst_i || mode != ctc_pkg::MODE_FREQ_WIDTH) begin
      fpw_armed <= 1'b0;
      fpw_captured <= 1'b0;
    end else if (do_clear) begin
      fpw_armed <= 1'b1;
      fpw_captured <= 1'b0;
    end else if (do_capture) begin
      fpw_captured <= 1'b1;
    end else if (do_stop) begin
      fpw_armed <= 1'b0;
      fpw_captured <= 1'b0;
    end
  end

  // Run state: free-running modes run whenever enabled
  always_ff @(posedge clk_i) begin
    if (rst_i || !control_primary[ctc_pkg::BIT_ENABLE]) begin
      run <= 1'b0;
    end else if (mode inside {ctc_pkg::MODE_PERIODIC, ctc_pkg::MODE_EIGHT_BIT_PULSE_MOD_MODE, ctc_pkg::MODE_CAPTURE}) begin
      run <= 1'b1;
    end else if (do_stop) begin
      run <= 1'b0;
    end else if (do_start) begin
      run <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= ctc_pkg::RESET_WORD;
    end else if (do_clear || (control_primary[ctc_pkg::BIT_SYNC] && companion_restart_i)) begin
      count <= ctc_pkg::RESET_WORD;
    end else if (tick && run) begin
      count <= (count == compare && !cap_mode) ? ctc_pkg::RESET_WORD : count + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture <= ctc_pkg::RESET_WORD;
    end else if (do_capture) begin
      capture <= count;
    end
  end

  // Set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_capture_flag <= 1'b0;
    end else if (do_flag) begin
      event_capture_flag <= 1'b1;
    end else if ((wr && adr_i == ctc_pkg::ADDR_INT_FLAGS && dat_i[0])
                 || (rd && adr_i == ctc_pkg::ADDR_CAPTURE && cap_mode)) begin
      event_capture_flag <= 1'b0;
    end
  end

  // Output level: single-shot high from start, falls at the stop only in async mode, which rises on the event itself
  always_comb begin
    out_set = 1'b0;
    if (mode == ctc_pkg::MODE_SINGLE) begin
      out_set = control_secondary[ctc_pkg::BIT_ASYNC] ? do_start : (do_start && tick);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !control_primary[ctc_pkg::BIT_ENABLE]) begin
      out_level <= rst_i ? 1'b0 : control_secondary[ctc_pkg::BIT_INIT];
    end else if (out_set || (mode == ctc_pkg::MODE_SINGLE && run && !control_secondary[ctc_pkg::BIT_ASYNC])) begin
      out_level <= 1'b1;
    end else if (mode == ctc_pkg::MODE_SINGLE && do_stop) begin
      out_level <= 1'b0;
    end else if (mode == ctc_pkg::MODE_EIGHT_BIT_PULSE_MOD_MODE) begin
      out_level <= (count[7:0] < compare[7:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_out_o <= 1'b0;
      irq_o <= 1'b0;
      running_o <= 1'b0;
    end else begin
      compare_out_o <= control_secondary[ctc_pkg::BIT_OUTEN] & out_level;
      irq_o <= irq_enable & event_capture_flag;
      running_o <= run;
    end
  end

  a_out_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(control_secondary[ctc_pkg::BIT_OUTEN]) |-> !compare_out_o)
    else $error("output not held low when disabled");
  a_irq_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_enable && event_capture_flag |=> irq_o)
    else $error("irq not raised");
  a_flag_event_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == ctc_pkg::MODE_CAPTURE && sel_edge |=> event_capture_flag && capture == $past(count))
    else $error("capture edge lost");
  a_no_event: assert property (@(posedge clk_i) disable iff (rst_i)
    !event_control[ctc_pkg::BIT_CAPTEN] |-> !do_capture && !do_start)
    else $error("event acted while disabled");
  a_disabled_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !control_primary[ctc_pkg::BIT_ENABLE] |=> !run)
    else $error("ran while disabled");
  a_freq_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == ctc_pkg::MODE_FREQ && sel_edge |=> count == 16'h0000 && event_capture_flag)
    else $error("frequency edge did not clear");
  // An edge in periodic or eight-bit pulse-modulation mode must leave the count on its plain increment path
  a_periodic_deaf: assert property (@(posedge clk_i) disable iff (rst_i)
    mode inside {ctc_pkg::MODE_PERIODIC, ctc_pkg::MODE_EIGHT_BIT_PULSE_MOD_MODE} && (rise || fall) && run && tick
    && count != compare && !(control_primary[ctc_pkg::BIT_SYNC] && companion_restart_i)
    |=> count == $past(count) + 16'h0001 && capture == $past(capture))
    else $error("event acted in free-run mode");
  a_flag_wclear: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == ctc_pkg::ADDR_INT_FLAGS && dat_i[0] && !do_flag |=> !event_capture_flag)
    else $error("flag not cleared");
  c_capture: cover property (@(posedge clk_i) mode == ctc_pkg::MODE_CAPTURE && do_capture);
  c_fpw_stop: cover property (@(posedge clk_i) mode == ctc_pkg::MODE_FREQ_WIDTH && do_stop);
  c_single: cover property (@(posedge clk_i) mode == ctc_pkg::MODE_SINGLE && do_start);
endmodule

// File: sim/ctc_partner.sv
// Event source and companion timer model facing the capture timer
module ctc_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic level_i,
  input wire logic tick_en_i,
  input wire logic restart_req_i,
  output logic event_o,
  output logic tick_o,
  output logic restart_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req_q;
  // Registered so each level lasts at least one whole clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_o <= 1'b0;
    end else begin
      event_o <= level_i;
    end
  end
  // Companion clock enable at half rate, silent while stopped
  always_ff @(posedge clk_i) begin
    if (rst_i || !tick_en_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= !tick_o;
    end
  end
  // One pulse per request, like a single companion overflow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
      restart_o <= 1'b0;
    end else begin
      req_q <= restart_req_i;
      restart_o <= restart_req_i && !req_q;
    end
  end
endmodule

// File: sim/tb.sv
// Self-checking bench for the capture timer control block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, we, sel, cyc, stb, sb, lvl, tk, rq;
  logic [3:0] adr;
  logic [7:0] dw, dr, q;
  logic ack, ev, tick, rst_c, cout, irq, run;
  logic [15:0] lfsr;
  int failures, num_checks, e_flag, e_run, ph;
  logic [7:0] evt [4] = '{8'h51, 8'h11, 8'h10, 8'h51};
  logic [7:0] ca [8] = '{8'h01, 8'h03, 8'h05, 8'h05, 8'h07, 8'h00, 8'h01, 8'h41};
  logic [7:0] tkv = 8'h08, sbv = 8'hc0, mv = 8'h8b;

  ctc_timer uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dw), .dat_o(dr), .we_i(we), .sel_i(sel),
    .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .event_i(ev), .companion_tick_i(tick), .companion_restart_i(rst_c),
    .standby_i(sb), .compare_out_o(cout), .irq_o(irq), .running_o(run));
  ctc_partner far (.clk_i(clk_i), .rst_i(rst_i), .level_i(lvl), .tick_en_i(tk), .restart_req_i(rq),
    .event_o(ev), .tick_o(tick), .restart_o(rst_c));

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic stop_test();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Holds the request until ack is seen; no latency is assumed
  task automatic bus(input logic [3:0] a, input logic w, input logic s, input logic [7:0] d);
    @(posedge clk_i);
    {cyc, stb, we, sel} <= {2'b11, w, s};
    adr <= a;
    dw <= d;
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dr;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, 1'b1, 1'b1, d);
  endtask
  task automatic moves(input logic e);
    logic [7:0] a;
    bus(4'ha, 1'b0, 1'b1, 8'h00);
    a = q;
    cy(20);
    bus(4'ha, 1'b0, 1'b1, 8'h00);
    chk({7'h00, a != q}, {7'h00, e});
  endtask
  // Model of one event edge: flag and run state predicted per mode
  task automatic step(input int m, input int p, input int r);
    int s;
    s = (r == (p == 0));
    @(posedge clk_i);
    lvl <= r[0];
    case (m)
      1: e_run = s;
      2: e_flag = e_flag | s;
      3: if (s) begin
        e_flag = 1;
        e_run = 1;
      end
      4: if (s) begin
        e_run = 1;
      end else begin
        e_flag = 1;
      end
      5: if (s && ph == 0) begin
        ph = 1;
        e_run = 1;
      end else if (!s && ph == 1) begin
        ph = 2;
      end else if (s && ph == 2) begin
        ph = 0;
        e_run = 0;
        e_flag = 1;
      end
      6: if (s) begin
        e_run = 1;
      end
      default: ;
    endcase
    cy(12);
    chk({7'h00, irq}, e_flag[7:0]);
    if (e_run >= 0) chk({7'h00, run}, e_run[7:0]);
    if (m == 6) chk({7'h00, cout}, e_run[7:0]);
    wr(4'h6, 8'h01);
    e_flag = 0;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = !clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    stop_test();
  end
  initial begin
    {rst_i, we, sel, cyc, stb, sb, lvl, tk, rq} = 9'h100;
    {adr, dw, failures, num_checks, lfsr} = {4'h0, 8'h00, 32'd0, 32'd0, 16'd6232};
    cy(10);
    rst_i <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      bus(i[3:0], 1'b0, 1'b1, 8'h00);
      chk(q, 8'h00); // Reset value and unmapped read
    end
    // Random bytes go in, enable bit cleared at address 0, so reserved bits must read back as zero
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      wr(i == 2 ? 4'h4 : i[3:0], lfsr[7:0] & (i == 0 ? 8'hfe : 8'hff));
      bus(i == 2 ? 4'h4 : i[3:0], 1'b0, 1'b1, 8'h00);
      chk(q, lfsr[7:0] & (i == 0 ? 8'h56 : i == 1 ? 8'h77 : 8'h51));
      wr(i == 2 ? 4'h4 : i[3:0], 8'h00);
    end
    wr(4'h2, 8'hff);
    bus(4'h4, 1'b1, 1'b0, 8'h51);
    bus(4'h2, 1'b0, 1'b1, 8'h00);
    chk(q, 8'h00);
    bus(4'h4, 1'b0, 1'b1, 8'h00);
    chk(q, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(4'h1, i == 0 ? 8'h20 : i == 1 ? 8'h30 : 8'h10);
      cy(3);
      chk({7'h00, cout}, {7'h00, i == 1});
    end
    wr(4'h8, 8'hff);
    wr(4'h5, 8'h01);
    wr(4'h1, 8'h02);
    for (int i = 0; i < 8; i++) begin
      wr(4'h0, 8'h00);
      {tk, sb} <= {tkv[i], sbv[i]};
      wr(4'h0, ca[i]);
      moves(mv[i]);
    end
    sb <= 1'b0;
    wr(4'h0, 8'h11);
    cy(100);
    rq <= 1'b1;
    cy(1);
    rq <= 1'b0;
    bus(4'ha, 1'b0, 1'b1, 8'h00);
    chk({7'h00, q < 8'h08}, 8'h01);
    // A short pulse must be swallowed by the filter and pass with the filter bypassed unless capture is disabled, a long one must pass
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 8'h00);
      wr(4'h4, evt[i]);
      wr(4'h0, 8'h01);
      wr(4'h6, 8'h01);
      lvl <= 1'b1;
      cy(i == 3 ? 8 : 2);
      lvl <= 1'b0;
      cy(12);
      chk({7'h00, irq}, {7'h00, i[0]});
      bus(4'h9, 1'b0, 1'b1, 8'h00);
      cy(3);
      chk({7'h00, irq}, 8'h00);
    end
    for (int m = 0; m < 8; m++) for (int p = 0; p < 2; p++) begin
      lfsr = nxt(lfsr);
      wr(4'h0, 8'h00);
      wr(4'h1, {1'b0, lfsr[0], 2'b01, 1'b0, m[2:0]});
      wr(4'h4, {1'b0, lfsr[1], 1'b0, p[0], 4'h1});
      // A companion restart zeroes the count, so no pass reaches the top by accident
      wr(4'h0, 8'h11);
      rq <= 1'b1;
      cy(1);
      rq <= 1'b0;
      wr(4'h6, 8'h01);
      e_flag = 0;
      ph = 0;
      e_run = (m == 0 || m == 2 || m == 7) ? 1 : (m == 1 || m == 6) ? 0 : -1;
      for (int k = 0; k < 4; k++) step(m, p, (k + 1) % 2);
    end
    stop_test();
  end
endmodule
